/* hw/mcmpwm_chan.sv */
`timescale 1ns/1ps
`default_nettype none
// One modulated output: single or double edge
module mcmpwm_chan (
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic enable,
	input wire logic double_edge,
	input wire logic cycle_start,
	input wire logic set_match,
	input wire logic clr_match,
	input wire logic fall_match,
	output logic level
);
	logic level_reg;
	logic level_next;
	logic rise_hit;
	logic fall_hit;

	// Edge sources by mode; clear wins so a constant low stays low
	assign rise_hit = double_edge ? set_match : cycle_start;
	assign fall_hit = double_edge ? clr_match : fall_match;
	assign level_next = !enable ? 1'b0 : fall_hit ? 1'b0 : rise_hit ? 1'b1 : level_reg;
	assign level = level_reg;

	// Output flop
	always_ff @(posedge mclk) begin
		if (reset) begin
			level_reg <= 1'b0;
		end else if (ce) begin
			level_reg <= level_next;
		end
	end
endmodule
`default_nettype wire

/* hw/mcmpwm_pkg.sv */
package mcmpwm_pkg;
	localparam int MCMPWM_NUM_MATCH = 7;
	localparam int MCMPWM_NUM_OUT = 6;
	// Register byte offsets
	localparam logic [7:0] MCMPWM_OFF_IRQ_STATUS = 8'h00;
	localparam logic [7:0] MCMPWM_OFF_CTRL = 8'h04;
	localparam logic [7:0] MCMPWM_OFF_COUNT = 8'h08;
	localparam logic [7:0] MCMPWM_OFF_PRESCALE = 8'h0C;
	localparam logic [7:0] MCMPWM_OFF_PRESCALE_COUNT = 8'h10;
	localparam logic [7:0] MCMPWM_OFF_MATCH_CTRL = 8'h14;
	localparam logic [7:0] MCMPWM_OFF_MATCH_BASE = 8'h18;
	localparam logic [7:0] MCMPWM_OFF_PWM_CTRL = 8'h34;
	localparam logic [7:0] MCMPWM_OFF_LATCH_EN = 8'h38;
	localparam logic [7:0] MCMPWM_OFF_IRQ_CLEAR = 8'h3C;
	localparam logic [7:0] MCMPWM_OFF_IRQ_ENABLE = 8'h40;
	// Control register fields
	localparam int MCMPWM_CTRL_COUNT_EN = 0;
	localparam int MCMPWM_CTRL_COUNT_RST = 1;
	localparam int MCMPWM_CTRL_PWM_EN = 3;
	// Match control: three bits per match, interrupt / reset / stop
	localparam int MCMPWM_MC_IRQ = 0;
	localparam int MCMPWM_MC_RESET = 1;
	localparam int MCMPWM_MC_STOP = 2;
	localparam int MCMPWM_MC_BITS = 3;
	// Pwm control: bits 2..6 select double edge, bits 9..14 enable outputs
	localparam int MCMPWM_PC_SEL_LO = 2;
	localparam int MCMPWM_PC_ENA_LO = 9;
	// Reset values
	localparam logic [31:0] MCMPWM_RST_WORD = 32'h0000_0000;
	localparam logic [31:0] MCMPWM_UNMAPPED_READ = 32'h0000_0000;
endpackage

/* hw/mcmpwm_top.sv */
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mcmpwm_top
	import mcmpwm_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	output logic [mcmpwm_pkg::MCMPWM_NUM_OUT-1:0] pwm_out
);
	import mcmpwm_pkg::*;

	logic [31:0] count_reg;
	logic [31:0] prescale_reg;
	logic [31:0] pcount_reg;
	logic [3:0] ctrl_reg;
	logic [20:0] match_ctrl_reg;
	logic [14:0] pwm_ctrl_reg;
	logic [6:0] latch_en_reg;
	logic [6:0] status_reg;
	logic [6:0] irq_en_reg;
	logic [31:0] shadow_reg [MCMPWM_NUM_MATCH];
	logic [31:0] active_reg [MCMPWM_NUM_MATCH];
	logic [31:0] readdata_reg;
	logic ack_reg;
	logic irq_reg;
	logic [MCMPWM_NUM_OUT-1:0] pwm_reg;
	logic [31:0] be_mask;
	logic bus_wr;
	logic bus_rd;
	logic wr_ctrl;
	logic wr_count;
	logic wr_prescale;
	logic wr_pcount;
	logic wr_mctrl;
	logic wr_pctrl;
	logic wr_latch;
	logic wr_clear;
	logic wr_ien;
	logic [6:0] wr_match;
	logic run;
	logic tick;
	logic pwm_mode;
	logic [6:0] hit;
	logic [6:0] hit_stop;
	logic [6:0] hit_reset;
	logic [6:0] hit_irq;
	logic any_stop;
	logic any_reset;
	logic cycle_reset;
	logic [6:0] clear_bits;
	logic [6:0] status_next;
	logic [31:0] rd_mux;
	logic [MCMPWM_NUM_OUT-1:0] pwm_level;
	logic [31:0] count_next;
	logic [31:0] pcount_next;

	// Bus decode; a write lands on the answer edge, so a held request writes again on every second edge
	assign bus_wr = avs_write && ack_reg;
	assign bus_rd = avs_read && !ack_reg;
	assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign wr_ctrl = bus_wr && avs_address == MCMPWM_OFF_CTRL;
	assign wr_count = bus_wr && avs_address == MCMPWM_OFF_COUNT;
	assign wr_prescale = bus_wr && avs_address == MCMPWM_OFF_PRESCALE;
	assign wr_pcount = bus_wr && avs_address == MCMPWM_OFF_PRESCALE_COUNT;
	assign wr_mctrl = bus_wr && avs_address == MCMPWM_OFF_MATCH_CTRL;
	assign wr_pctrl = bus_wr && avs_address == MCMPWM_OFF_PWM_CTRL;
	assign wr_latch = bus_wr && avs_address == MCMPWM_OFF_LATCH_EN;
	assign wr_clear = bus_wr && avs_address == MCMPWM_OFF_IRQ_CLEAR;
	assign wr_ien = bus_wr && avs_address == MCMPWM_OFF_IRQ_ENABLE;
	for (genvar i = 0; i < MCMPWM_NUM_MATCH; i++) begin : g_wdec
		assign wr_match[i] = bus_wr && avs_address == MCMPWM_OFF_MATCH_BASE + 8'(4 * i);
	end

	// Prescaler and counter enables
	assign run = ctrl_reg[MCMPWM_CTRL_COUNT_EN] && !ctrl_reg[MCMPWM_CTRL_COUNT_RST];
	assign tick = run && (pcount_reg == prescale_reg);
	assign pwm_mode = ctrl_reg[MCMPWM_CTRL_PWM_EN];

	// Match compare on the active set; one count per hit gives full resolution
	for (genvar i = 0; i < MCMPWM_NUM_MATCH; i++) begin : g_hit
		assign hit[i] = tick && (count_reg == active_reg[i]);
		assign hit_irq[i] = hit[i] && match_ctrl_reg[MCMPWM_MC_BITS * i + MCMPWM_MC_IRQ];
		assign hit_reset[i] = hit[i] && match_ctrl_reg[MCMPWM_MC_BITS * i + MCMPWM_MC_RESET];
		assign hit_stop[i] = hit[i] && match_ctrl_reg[MCMPWM_MC_BITS * i + MCMPWM_MC_STOP];
	end
	assign any_stop = |hit_stop;
	assign any_reset = |hit_reset;
	assign cycle_reset = hit_reset[0];

	// Counter next value: reset beats increment
	assign count_next = any_reset ? 32'h0000_0000 : count_reg + 32'h0000_0001;
	assign pcount_next = tick ? 32'h0000_0000 : pcount_reg + 32'h0000_0001;

	// Sticky flags; a new hit wins over a same-cycle clear
	assign clear_bits = wr_clear ? avs_writedata[6:0] : 7'h00;
	assign status_next = (status_reg & ~clear_bits) | hit_irq;

	// Read mux; unmapped reads return zero
	always_comb begin
		rd_mux = MCMPWM_UNMAPPED_READ;
		case (avs_address)
			MCMPWM_OFF_IRQ_STATUS: rd_mux = {25'h000_0000, status_reg};
			MCMPWM_OFF_CTRL: rd_mux = {28'h000_0000, ctrl_reg};
			MCMPWM_OFF_COUNT: rd_mux = count_reg;
			MCMPWM_OFF_PRESCALE: rd_mux = prescale_reg;
			MCMPWM_OFF_PRESCALE_COUNT: rd_mux = pcount_reg;
			MCMPWM_OFF_MATCH_CTRL: rd_mux = {11'h000, match_ctrl_reg};
			MCMPWM_OFF_PWM_CTRL: rd_mux = {17'h0_0000, pwm_ctrl_reg};
			MCMPWM_OFF_LATCH_EN: rd_mux = {25'h000_0000, latch_en_reg};
			MCMPWM_OFF_IRQ_ENABLE: rd_mux = {25'h000_0000, irq_en_reg};
			default: begin
				for (int k = 0; k < MCMPWM_NUM_MATCH; k++) begin
					if (avs_address == MCMPWM_OFF_MATCH_BASE + 8'(4 * k)) begin
						rd_mux = shadow_reg[k];
					end
				end
			end
		endcase
	end

	// Bus answer, one wait state per access
	always_ff @(posedge mclk) begin
		if (reset) begin
			ack_reg <= 1'b0;
			readdata_reg <= MCMPWM_RST_WORD;
		end else if (ce) begin
			ack_reg <= (avs_read || avs_write) && !ack_reg;
			if (bus_rd) begin
				readdata_reg <= rd_mux;
			end
		end
	end
	assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
	assign avs_readdata = readdata_reg;

	// Control and configuration registers
	always_ff @(posedge mclk) begin
		if (reset) begin
			ctrl_reg <= 4'h0;
			prescale_reg <= MCMPWM_RST_WORD;
			match_ctrl_reg <= 21'h00_0000;
			pwm_ctrl_reg <= 15'h0000;
			irq_en_reg <= 7'h00;
		end else if (ce) begin
			if (wr_ctrl) begin
				ctrl_reg <= (ctrl_reg & ~be_mask[3:0]) | (avs_writedata[3:0] & be_mask[3:0]);
			end else if (any_stop) begin
				ctrl_reg[MCMPWM_CTRL_COUNT_EN] <= 1'b0;
			end
			if (wr_prescale) begin
				prescale_reg <= (prescale_reg & ~be_mask) | (avs_writedata & be_mask);
			end
			if (wr_mctrl) begin
				match_ctrl_reg <= avs_writedata[20:0];
			end
			if (wr_pctrl) begin
				pwm_ctrl_reg <= avs_writedata[14:0];
			end
			if (wr_ien) begin
				irq_en_reg <= avs_writedata[6:0];
			end
		end
	end

	// Counter and prescaler; a reset bit holds both at zero
	always_ff @(posedge mclk) begin
		if (reset) begin
			count_reg <= MCMPWM_RST_WORD;
			pcount_reg <= MCMPWM_RST_WORD;
		end else if (ce) begin
			if (ctrl_reg[MCMPWM_CTRL_COUNT_RST]) begin
				count_reg <= MCMPWM_RST_WORD;
				pcount_reg <= MCMPWM_RST_WORD;
			end else begin
				if (wr_count) begin
					count_reg <= avs_writedata;
				end else if (tick && !any_stop) begin
					count_reg <= count_next;
				end
				if (wr_pcount) begin
					pcount_reg <= avs_writedata;
				end else if (run) begin
					pcount_reg <= pcount_next;
				end
			end
		end
	end

	// Shadow writes and release; outside pwm mode writes go straight through
	always_ff @(posedge mclk) begin
		if (reset) begin
			latch_en_reg <= 7'h00;
			for (int k = 0; k < MCMPWM_NUM_MATCH; k++) begin
				shadow_reg[k] <= MCMPWM_RST_WORD;
				active_reg[k] <= MCMPWM_RST_WORD;
			end
		end else if (ce) begin
			for (int k = 0; k < MCMPWM_NUM_MATCH; k++) begin
				if (wr_match[k]) begin
					shadow_reg[k] <= avs_writedata;
				end
				if (!pwm_mode && wr_match[k]) begin
					active_reg[k] <= avs_writedata;
				end else if (pwm_mode && cycle_reset && latch_en_reg[k]) begin
					active_reg[k] <= shadow_reg[k];
				end
			end
			// Release bits self-clear once taken; a new release wins
			if (wr_latch) begin
				latch_en_reg <= latch_en_reg | avs_writedata[6:0];
			end else if (pwm_mode && cycle_reset) begin
				latch_en_reg <= 7'h00;
			end
		end
	end

	// Interrupt status and level output
	always_ff @(posedge mclk) begin
		if (reset) begin
			status_reg <= 7'h00;
			irq_reg <= 1'b0;
		end else if (ce) begin
			status_reg <= status_next;
			irq_reg <= |(status_next & irq_en_reg);
		end
	end
	assign irq = irq_reg;

	// Output n uses match n; double edge rises on n-1, falls on n
	for (genvar n = 1; n <= MCMPWM_NUM_OUT; n++) begin : g_chan
		mcmpwm_chan u_chan (
			.mclk(mclk),
			.reset(reset),
			.ce(ce),
			.enable(pwm_mode && pwm_ctrl_reg[MCMPWM_PC_ENA_LO + n - 1]),
			.double_edge(n >= 2 && pwm_ctrl_reg[n]),
			.cycle_start(cycle_reset && pwm_mode),
			.set_match(hit[n - 1]),
			.clr_match(hit[n]),
			.fall_match(hit[n]),
			.level(pwm_level[n - 1])
		);
	end

	// Registered copy so pins come from a flop stage
	always_ff @(posedge mclk) begin
		if (reset) begin
			pwm_reg <= '0;
		end else if (ce) begin
			pwm_reg <= pwm_level;
		end
	end
	assign pwm_out = pwm_reg;
endmodule
`default_nettype wire

/* test/mcmpwm_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// Bus handshake and reset checks on the top ports
module mcmpwm_monitor
	import mcmpwm_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic irq,
	input wire logic [mcmpwm_pkg::MCMPWM_NUM_OUT-1:0] pwm_out
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	// Request taken, then answered
	sequence s_take;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_ack;
		(avs_read || avs_write) && !avs_waitrequest;
	endsequence
	chk_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("no wait state on new request");
	chk_one_wait: assert property (s_take |=> s_ack)
		else $error("answer not after one wait state");
	chk_idle_free: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest without request");
	chk_ack_rearm: assert property (s_ack |=> !(avs_read || avs_write) || avs_waitrequest)
		else $error("request answered twice");
	chk_unmapped_zero: assert property (s_ack and avs_read && avs_address == 8'h44
		|-> avs_readdata == MCMPWM_UNMAPPED_READ) else $error("unmapped read not zero");
	chk_clear_reads: assert property (s_ack and avs_read && avs_address == MCMPWM_OFF_IRQ_CLEAR
		|-> avs_readdata == 32'h0000_0000) else $error("clear register read not zero");
	// Read data must not move between reads
	chk_rdata_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
		else $error("read data moved without read");
	chk_reset_quiet: assert property ($past(reset) |-> pwm_out == '0 && !irq)
		else $error("outputs active after reset");
endmodule
bind mcmpwm_top mcmpwm_monitor u_mon(.mclk, .reset, .ce, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .pwm_out);
`default_nettype wire

/* test/mcmpwm_stage.sv */
`timescale 1ns/1ps
`default_nettype none
// Power stage inputs: report a finished high pulse, at most one per cycle
module mcmpwm_stage (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [5:0] pwm_out,
	output logic done,
	output logic [2:0] ch,
	output logic [31:0] width
);
	logic [31:0] hi [6];
	logic [5:0] last;
	// Only one fall per cycle is reported, so falls are staggered
	always @(posedge mclk) begin
		done <= 1'b0;
		for (int c = 0; c < 6; c++) begin
			hi[c] <= (pwm_out[c] && !reset) ? hi[c] + 1 : 0;
			if (last[c] && !pwm_out[c]) begin
				done <= 1'b1;
				ch <= 3'(c);
				width <= hi[c];
			end
		end
		last <= reset ? 6'h0 : pwm_out;
	end
endmodule
`default_nettype wire

/* test/tb_multi_channel_match_pwm.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_multi_channel_match_pwm;
	import mcmpwm_pkg::*;
	logic mclk = 0;
	logic reset = 1;
	logic rd = 0;
	logic wr = 0;
	logic no_pwm = 0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata, avs_readdata, width;
	logic [32:0] rdq[$];
	logic [31:0] pq[6][$];
	logic avs_waitrequest, irq, done;
	logic [5:0] pwm_out;
	logic [2:0] ch;
	int err_total = 0;
	int checks = 0;
	int seed = 32'hbf41_aee1;
	int k, m2, m5;
	int mv[7];
	always #2.5 mclk = ~mclk;
	mcmpwm_top u_dut(.mclk, .reset, .ce(1'b1), .avs_address(addr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata,
		.avs_waitrequest, .irq, .pwm_out);
	mcmpwm_stage u_stage(.mclk, .reset, .pwm_out, .done, .ch, .width);
	task check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task check_pulse(input logic [31:0] got, input logic [31:0] exp);
		check(got, exp);
	endtask
	task check_level(input logic got, input logic exp);
		check({31'h0, got}, {31'h0, exp});
	endtask
	task results;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// One bus cycle; reads leave a note, checked or not
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d = 0,
		input logic c = 0, input logic [31:0] e = 0);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		if (!w) rdq.push_back({c, e});
		// Hold the request until waitrequest is seen low at a rising edge
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		rdata = avs_readdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task drain;
		while (pq[0].size() + pq[1].size() + pq[2].size() + pq[3].size() + pq[4].size())
			@(posedge mclk);
	endtask
	// Watcher: read answers and finished pulses against the oldest notes
	always @(negedge mclk) begin
		logic [32:0] n;
		if (rd && avs_waitrequest === 1'b0) begin
			n = rdq.pop_front();
			if (n[32]) check(avs_readdata, n[31:0]);
		end
		if (done === 1'b1 && pq[ch].size() > 0) check_pulse(width, pq[ch].pop_front());
		if (pwm_out[5] === 1'b1) check_level(1'b1, 1'b0);
		if (no_pwm) check_level(|pwm_out, 1'b0);
	end
	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		results();
	end
	initial begin
		k = ($random(seed) & 3) + 1;
		m2 = 12 + ($random(seed) & 7);
		m5 = 20 + ($random(seed) & 7);
		// Output 6 falls on the cycle match itself, so it is a constant low
		mv = '{40, 5, m2, 30, 10, m5, 40};
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		bus(0, MCMPWM_OFF_PRESCALE, 0, 1, MCMPWM_RST_WORD);
		bus(0, 8'h44, 0, 1, 32'h0000_0000);
		bus(0, MCMPWM_OFF_IRQ_CLEAR, 0, 1, 32'h0000_0000);
		bus(1, MCMPWM_OFF_PRESCALE, k - 1);
		// Matches written before modulation go straight to active
		for (int i = 0; i < 7; i++) bus(1, MCMPWM_OFF_MATCH_BASE + 8'(4 * i), mv[i]);
		bus(1, MCMPWM_OFF_MATCH_CTRL, 32'h0000_0003);
		bus(1, MCMPWM_OFF_PWM_CTRL, 32'h0000_7e14);
		bus(1, MCMPWM_OFF_IRQ_ENABLE, 32'h0000_0001);
		repeat (2) begin
			pq[0].push_back(6 * k);
			pq[1].push_back((m2 - 5) * k);
			pq[2].push_back(31 * k);
			pq[3].push_back(21 * k);
			pq[4].push_back((m5 + 1) * k);
		end
		bus(1, MCMPWM_OFF_CTRL, 32'h0000_0009);
		drain();
		// Unreleased value must not reach the output
		bus(1, 8'h2c, 28);
		pq[4].push_back((m5 + 1) * k);
		drain();
		bus(0, 8'h2c, 0, 1, 28);
		bus(1, MCMPWM_OFF_LATCH_EN, 32'h0000_0020);
		pq[4].push_back(29 * k);
		drain();
		// Stop on cycle match, then raise, mask and clear the interrupt
		bus(1, MCMPWM_OFF_MATCH_CTRL, 32'h0000_0005);
		do bus(0, MCMPWM_OFF_CTRL); while (rdata[0] !== 1'b0);
		bus(0, MCMPWM_OFF_CTRL, 0, 1, 32'h0000_0008);
		@(negedge mclk);
		check_level(irq, 1'b1);
		bus(1, MCMPWM_OFF_IRQ_STATUS, 32'h0000_0000);
		bus(0, MCMPWM_OFF_IRQ_STATUS, 0, 1, 32'h0000_0001);
		bus(1, MCMPWM_OFF_IRQ_ENABLE, 32'h0000_0000);
		// Irq follows the enable one clock after the write lands
		repeat (2) @(negedge mclk);
		check_level(irq, 1'b0);
		bus(1, MCMPWM_OFF_IRQ_CLEAR, 32'h0000_0001);
		bus(0, MCMPWM_OFF_IRQ_STATUS, 0, 1, 32'h0000_0000);
		bus(1, MCMPWM_OFF_IRQ_ENABLE, 32'h0000_0001);
		repeat (2) @(negedge mclk);
		check_level(irq, 1'b0);
		// Plain timer: counter runs through the matches, pins stay low
		bus(1, MCMPWM_OFF_MATCH_CTRL, 32'h0000_0002);
		bus(1, MCMPWM_OFF_CTRL, 32'h0000_0001);
		repeat (3) @(posedge mclk);
		no_pwm = 1'b1;
		repeat (200) @(posedge mclk);
		no_pwm = 1'b0;
		bus(0, MCMPWM_OFF_CTRL, 0, 1, 32'h0000_0001);
		results();
	end
endmodule
`default_nettype wire
